// File: rtl/pmrc_top.sv
// power mode and reset controller: active, standby and sleep modes,
// six reset sources collected into stretched system and cpu resets.
// assumes i_sys_rst is the power-on reset and all inputs are synchronous.
`timescale 1ns/1ps
module pmrc_top
	import pmrc_pkg::*;
#(
	parameter int DEB_CYC     = DEBOUNCE_CYC,
	parameter int CPU_RST_CYC = CPU_RST_CYCLES,
	parameter int SYS_RST_CYC = SYS_RST_CYCLES
) (
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	input  wire logic        i_halt,
	input  wire logic        i_irq_pending,
	input  wire logic        i_reset_pin,
	input  wire logic [3:0]  i_input_port_pins,
	input  wire logic        i_wdog_expired,
	input  wire logic        i_osc_stopped,
	input  wire logic        i_level_busy,
	input  wire logic        i_port_write,
	output logic             o_sys_rst,
	output logic             o_cpu_rst,
	output logic             o_cpu_clk_en,
	output logic             o_osc_en,
	output logic             o_periph_en,
	output logic             o_level_en,
	output logic             o_bidir_hiz,
	output logic             o_input_port_en,
	output logic             o_strobe,
	output logic [1:0]       o_mode
);

	////////////////////////////////////////////////////////////////
	// register state
	pmrc_mode_t  mode_q;
	pmrc_opt_t   opt_q;
	logic        permit_q;
	logic        sleep_flag_q;
	logic        inhibit_q;
	logic [31:0] sys_cnt_q;
	logic [31:0] cpu_cnt_q;
	logic [31:0] pin_cnt_q;
	logic [31:0] port_cnt_q;
	logic        sys_rst_q;
	logic        cpu_rst_q;
	logic [3:0]  term;
	logic        combo;
	logic        pin_fire;
	logic        port_fire;
	logic        osc_fire;
	logic        sleep_go;
	logic        rst_src;
	logic        wake;
	logic        wr_go;
	logic [7:0]  aw_q;
	logic [31:0] w_q;
	logic        aw_have_q;
	logic        w_have_q;

	////////////////////////////////////////////////////////////////
	// reset source detection
	generate
		for (genvar n = 0; n < 4; n++) begin : g_term
			always_comb begin
				case ({opt_q.sel_one[n], opt_q.sel_two[n]})
					2'b00:   term[n] = 1'b0;
					2'b01:   term[n] = i_input_port_pins[n];
					2'b10:   term[n] = ~i_input_port_pins[n];
					default: term[n] = 1'b1;
				endcase
			end
		end
	endgenerate
	assign combo = &term;

	// sleep uses the short filter, otherwise the debouncer
	assign pin_fire  = (mode_q == PMRC_SLEEP) ? (pin_cnt_q == 32'(PIN_FILT_CYC - 1)) && i_reset_pin
						: (pin_cnt_q == 32'(DEB_CYC - 1)) && i_reset_pin;
	// sleep wake by combination is immediate and only with the option set
	assign port_fire = (mode_q == PMRC_SLEEP) ? combo && opt_q.wake_opt
						: (port_cnt_q == 32'(DEB_CYC - 1)) && combo;
	// supervisor is blind while the oscillator is off or starting
	assign osc_fire  = i_osc_stopped && !inhibit_q
						&& (mode_q == PMRC_ACTIVE || mode_q == PMRC_STANDBY);
	assign wr_go     = aw_have_q && w_have_q && !o_bvalid;
	assign sleep_go  = wr_go && aw_q == SYS_CTRL_ONE_OFS && w_q[SLEEP_BIT]
						&& permit_q && mode_q == PMRC_ACTIVE;
	assign wake      = (mode_q == PMRC_SLEEP) && (pin_fire || port_fire);
	assign rst_src   = pin_fire || port_fire || i_wdog_expired || osc_fire || sleep_go;

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !i_reset_pin) begin
			pin_cnt_q <= 32'h0000_0000;
		end else if (!pin_fire) begin
			pin_cnt_q <= pin_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !combo || mode_q == PMRC_SLEEP) begin
			port_cnt_q <= 32'h0000_0000;
		end else if (!port_fire) begin
			port_cnt_q <= port_cnt_q + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// reset stretching
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || rst_src) begin
			sys_cnt_q <= 32'(SYS_RST_CYC - 1);
			sys_rst_q <= 1'b1;
		end else if (sys_cnt_q != 32'h0000_0000) begin
			sys_cnt_q <= sys_cnt_q - 32'h0000_0001;
			sys_rst_q <= 1'b1;
		end else begin
			sys_rst_q <= (mode_q == PMRC_SLEEP);
		end
	end

	// cpu delay only runs once the oscillator is running again
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || rst_src || mode_q == PMRC_SLEEP) begin
			cpu_cnt_q <= 32'(CPU_RST_CYC - 1);
			cpu_rst_q <= 1'b1;
		end else if (cpu_cnt_q != 32'h0000_0000) begin
			cpu_cnt_q <= cpu_cnt_q - 32'h0000_0001;
			cpu_rst_q <= 1'b1;
		end else begin
			cpu_rst_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// mode machine
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			mode_q <= PMRC_WAKE;
		end else begin
			case (mode_q)
				PMRC_ACTIVE: begin
					if (sleep_go) begin
						mode_q <= PMRC_SLEEP;
					end else if (rst_src) begin
						mode_q <= PMRC_WAKE;
					end else if (i_halt && !cpu_rst_q) begin
						mode_q <= PMRC_STANDBY;
					end
				end
				PMRC_STANDBY: begin
					if (rst_src) begin
						mode_q <= PMRC_WAKE;
					end else if (i_irq_pending) begin
						mode_q <= PMRC_ACTIVE;
					end
				end
				PMRC_SLEEP: begin
					if (wake) begin
						mode_q <= PMRC_WAKE;
					end
				end
				default: begin
					if (cpu_cnt_q == 32'h0000_0000 && !cpu_rst_q) begin
						mode_q <= PMRC_ACTIVE;
					end else if (sleep_go) begin
						mode_q <= PMRC_SLEEP;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || wake) begin
			sleep_flag_q <= 1'b0;
		end else if (sleep_go) begin
			sleep_flag_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// pin and clock controls, all registered
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_cpu_clk_en    <= 1'b0;
			o_osc_en        <= 1'b1;
			o_periph_en     <= 1'b1;
			o_level_en      <= 1'b0;
			o_bidir_hiz     <= 1'b0;
			o_input_port_en <= 1'b1;
			o_strobe        <= 1'b1;
			o_mode          <= PMRC_WAKE;
		end else begin
			// halted cpu keeps state because its clock is simply gated
			o_cpu_clk_en    <= mode_q == PMRC_ACTIVE && !cpu_rst_q;
			o_osc_en        <= mode_q != PMRC_SLEEP;
			o_periph_en     <= mode_q != PMRC_SLEEP;
			o_level_en      <= mode_q == PMRC_ACTIVE
						|| (mode_q == PMRC_STANDBY && i_level_busy && o_level_en);
			o_bidir_hiz     <= mode_q == PMRC_SLEEP;
			o_input_port_en <= mode_q != PMRC_SLEEP || opt_q.wake_opt;
			case (opt_q.strobe_sel)
				2'h0:    o_strobe <= cpu_rst_q;
				2'h1:    o_strobe <= i_port_write;
				2'h2:    o_strobe <= sleep_flag_q;
				default: o_strobe <= cpu_rst_q || i_port_write;
			endcase
			o_mode          <= mode_q;
		end
	end
	assign o_sys_rst = sys_rst_q;
	assign o_cpu_rst = cpu_rst_q;

	////////////////////////////////////////////////////////////////
	// axi4-lite write side
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_q      <= 8'h00;
			w_q       <= 32'h0000_0000;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= {i_awaddr[7:2], 2'b00};
			end
			if (i_wvalid && o_wready) begin
				w_have_q <= 1'b1;
				w_q      <= i_wstrb[0] ? i_wdata : 32'h0000_0000;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				o_bvalid  <= 1'b1;
				o_bresp   <= (aw_q > STATUS_OFS) ? RESP_SLVERR : RESP_OKAY;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end
	assign o_awready = !aw_have_q && !o_bvalid;
	assign o_wready  = !w_have_q && !o_bvalid;

	// only power-on clears the options and the permit latch
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			opt_q    <= '{SEL_RST, SEL_RST, 1'b0, STROBE_RST};
			permit_q <= 1'b0;
		end else if (wr_go) begin
			case (aw_q)
				SYS_CTRL_TWO_OFS: permit_q         <= w_q[PERMIT_BIT];
				RST_SEL_ONE_OFS:  opt_q.sel_one    <= w_q[3:0];
				RST_SEL_TWO_OFS:  opt_q.sel_two    <= w_q[3:0];
				WAKE_OPT_OFS:     opt_q.wake_opt   <= w_q[WAKE_BIT];
				DISP_CTRL_OFS:    opt_q.strobe_sel <= w_q[1:0];
				default: ;
			endcase
		end
	end

	// inhibit is cleared by every system reset
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || sys_rst_q) begin
			inhibit_q <= 1'b0;
		end else if (wr_go && aw_q == LVL_CTRL_OFS) begin
			inhibit_q <= w_q[INHIBIT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// axi4-lite read side
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h0000_0000;
			o_rresp  <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rresp  <= RESP_OKAY;
			case ({i_araddr[7:2], 2'b00})
				SYS_CTRL_ONE_OFS: o_rdata <= 32'(sleep_flag_q);
				SYS_CTRL_TWO_OFS: o_rdata <= 32'({permit_q, 2'b00});
				RST_SEL_ONE_OFS:  o_rdata <= 32'(opt_q.sel_one);
				RST_SEL_TWO_OFS:  o_rdata <= 32'(opt_q.sel_two);
				WAKE_OPT_OFS:     o_rdata <= 32'(opt_q.wake_opt);
				LVL_CTRL_OFS:     o_rdata <= 32'(inhibit_q);
				DISP_CTRL_OFS:    o_rdata <= 32'(opt_q.strobe_sel);
				STATUS_OFS:       o_rdata <= 32'({cpu_rst_q, sys_rst_q, mode_q});
				default: begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (o_rvalid && i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
	assign o_arready = !o_rvalid;

endmodule

// File: rtl/pmrc_pkg.sv
// package for the power mode and reset controller
// assumes a 100 MHz i_ref_clk and a 32-bit AXI4-Lite register bus
package pmrc_pkg;
	// register byte offsets
	localparam logic [7:0] SYS_CTRL_ONE_OFS = 8'h00;
	localparam logic [7:0] SYS_CTRL_TWO_OFS = 8'h04;
	localparam logic [7:0] RST_SEL_ONE_OFS  = 8'h08;
	localparam logic [7:0] RST_SEL_TWO_OFS  = 8'h0C;
	localparam logic [7:0] WAKE_OPT_OFS     = 8'h10;
	localparam logic [7:0] LVL_CTRL_OFS     = 8'h14;
	localparam logic [7:0] DISP_CTRL_OFS    = 8'h18;
	localparam logic [7:0] STATUS_OFS       = 8'h1C;
	// field positions
	localparam int SLEEP_BIT   = 0;
	localparam int PERMIT_BIT  = 2;
	localparam int WAKE_BIT    = 0;
	localparam int INHIBIT_BIT = 0;
	// reset values
	localparam logic [3:0] SEL_RST    = 4'h0;
	localparam logic [1:0] STROBE_RST = 2'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int PIN_FILT_NS    = 10000;
	localparam int PIN_FILT_CYC   = (PIN_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEBOUNCE_MS    = 16;
	localparam int DEBOUNCE_CYC   = (DEBOUNCE_MS * 1000000) / CLK_PERIOD_NS;
	localparam int CPU_RST_CYCLES = 32768;
	localparam int SYS_RST_CYCLES = 16;

	typedef enum logic [1:0] {
		PMRC_ACTIVE  = 2'b00,
		PMRC_STANDBY = 2'b01,
		PMRC_SLEEP   = 2'b10,
		PMRC_WAKE    = 2'b11
	} pmrc_mode_t;

	typedef struct packed {
		logic [3:0] sel_one;
		logic [3:0] sel_two;
		logic       wake_opt;
		logic [1:0] strobe_sel;
	} pmrc_opt_t;
endpackage

// File: test/pmrc_properties.sv
// timing checker for the power mode and reset controller
// bound into pmrc_top; sees only its ports
`timescale 1ns/1ps
module pmrc_chk
	import pmrc_pkg::*;
#(
	parameter int CPU_RST_CYC = 40,
	parameter int SYS_RST_CYC = 16
) (
	input wire logic       i_ref_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_halt,
	input wire logic       i_irq_pending,
	input wire logic       i_wdog_expired,
	input wire logic       i_osc_stopped,
	input wire logic       o_sys_rst,
	input wire logic       o_cpu_rst,
	input wire logic       o_cpu_clk_en,
	input wire logic       o_osc_en,
	input wire logic       o_periph_en,
	input wire logic       o_level_en,
	input wire logic       o_bidir_hiz,
	input wire logic [1:0] o_mode
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	int cpu_cnt_q;
	int sys_cnt_q;
	////////////////
	// cpu count only runs in start-up, so sleep time is not credited
	always_ff @(posedge i_ref_clk) begin
		cpu_cnt_q <= (i_sys_rst || !o_cpu_rst) ? 0 : cpu_cnt_q + (o_mode == PMRC_WAKE);
		sys_cnt_q <= (i_sys_rst || !o_sys_rst) ? 0 : sys_cnt_q + 1;
	end
	////////////////
	AST_SLEEP_RST: assert property (o_mode == PMRC_SLEEP |-> o_sys_rst && o_cpu_rst)
		else $error("reset low while asleep");
	AST_SLEEP_OFF: assert property (o_mode == PMRC_SLEEP [*2] |-> !o_osc_en && !o_periph_en && !o_level_en && o_bidir_hiz)
		else $error("sleep left a function on");
	AST_STBY_CLK: assert property (o_mode == PMRC_STANDBY [*2] |-> !o_cpu_clk_en && o_osc_en && o_periph_en)
		else $error("standby clocks wrong");
	// o_mode trails the mode register by one edge, hence two edges to see the move
	AST_HALT: assert property (o_mode == PMRC_ACTIVE && i_halt && !i_wdog_expired && !i_osc_stopped |-> ##2 o_mode == PMRC_STANDBY)
		else $error("halt did not enter standby");
	AST_IRQ: assert property (o_mode == PMRC_STANDBY && i_irq_pending && !i_wdog_expired && !i_osc_stopped |-> ##2 o_mode == PMRC_ACTIVE)
		else $error("interrupt did not end standby");
	AST_WDOG: assert property (i_wdog_expired && !o_sys_rst |-> ##[1:2] o_sys_rst && o_cpu_rst)
		else $error("watchdog reset missing");
	AST_CPU_DLY: assert property ($fell(o_cpu_rst) |-> cpu_cnt_q >= CPU_RST_CYC - 1 && cpu_cnt_q <= CPU_RST_CYC + 1 ##2 o_mode == PMRC_ACTIVE)
		else $error("cpu reset delay wrong");
	AST_SYS_DLY: assert property ($fell(o_sys_rst) |-> sys_cnt_q >= SYS_RST_CYC - 2 && o_cpu_rst)
		else $error("system reset stretch wrong");
endmodule
bind pmrc_top pmrc_chk #(.CPU_RST_CYC(CPU_RST_CYC), .SYS_RST_CYC(SYS_RST_CYC)) chk_u (.*);

// File: test/pmrc_far_model.sv
// far side: cpu core issuing halt, external party on the reset pin
// commanded by the bench on the same clock
`timescale 1ns/1ps
module pmrc_far_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_cpu_rst,
	input  wire logic        i_cpu_clk_en,
	input  wire logic        i_halt_req,
	input  wire logic        i_pin_go,
	input  wire logic [15:0] i_pin_cyc,
	output logic             o_halt,
	output logic             o_reset_pin
);
	logic [15:0] pin_left_q;
	initial pin_left_q = 16'h0;
	// a stopped or resetting cpu cannot execute halt
	assign o_halt = i_halt_req && !i_cpu_rst && i_cpu_clk_en;
	// pin falls back to its pull-down once the span ends
	assign o_reset_pin = (pin_left_q != 16'h0);
	always @(posedge i_ref_clk) begin
		if (i_pin_go)
			pin_left_q <= i_pin_cyc;
		else if (pin_left_q != 16'h0)
			pin_left_q <= pin_left_q - 16'h1;
	end
endmodule

// File: test/tb_top.sv
// bench for the power mode and reset controller
// drives the register bus and mode inputs; far model gives halt and reset pin
`timescale 1ns/1ps
module tb_top;
	import pmrc_pkg::*;
	localparam int DEB = 20;
	localparam int CPU = 40;
	localparam int PF = PIN_FILT_CYC;
	logic i_ref_clk = 1'b0;
	logic i_sys_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_halt, i_irq_pending, i_reset_pin;
	logic i_wdog_expired, i_osc_stopped, i_level_busy, i_port_write, halt_req, pin_go;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sys_rst, o_cpu_rst, o_cpu_clk_en;
	logic o_osc_en, o_periph_en, o_level_en, o_bidir_hiz, o_input_port_en, o_strobe;
	logic [1:0] o_bresp, o_rresp, o_mode;
	logic [3:0] i_wstrb, i_input_port_pins;
	logic [7:0] i_awaddr, i_araddr;
	logic [15:0] pin_cyc;
	logic [31:0] i_wdata, o_rdata;
	int miscompares = 0;
	int checks_done = 0;
	pmrc_top #(.DEB_CYC(DEB), .CPU_RST_CYC(CPU), .SYS_RST_CYC(6)) dut_u (.*);
	pmrc_far_model far_u (.i_ref_clk, .i_cpu_rst(o_cpu_rst), .i_cpu_clk_en(o_cpu_clk_en), .i_halt_req(halt_req),
		.i_pin_go(pin_go), .i_pin_cyc(pin_cyc), .o_halt(i_halt), .o_reset_pin(i_reset_pin));
	initial forever #5 i_ref_clk = ~i_ref_clk;
	////////////////
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_ref_clk);
	endtask
	task automatic wmode(input logic [1:0] m, input int lim);
		for (int k = 0; k < lim && o_mode !== m; k++)
			@(negedge i_ref_clk);
		chk("mode", m, o_mode);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh, bh;
		logic [1:0] r;
		@(posedge i_ref_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(negedge i_ref_clk);
			ah = i_awvalid && o_awready;
			wh = i_wvalid && o_wready;
			bh = o_bvalid;
			r = o_bresp;
			@(posedge i_ref_clk);
			if (ah)
				i_awvalid <= 1'b0;
			if (wh)
				i_wvalid <= 1'b0;
		end while (!bh);
		i_bready <= 1'b0;
		chk("bresp", er, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		logic ah, rh;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge i_ref_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(negedge i_ref_clk);
			ah = i_arvalid && o_arready;
			rh = o_rvalid;
			d = o_rdata;
			r = o_rresp;
			@(posedge i_ref_clk);
			if (ah)
				i_arvalid <= 1'b0;
		end while (!rh);
		i_rready <= 1'b0;
		chk("rdata", e, d & m);
		chk("rresp", er, r);
	endtask
	task automatic drive(input logic h, input logic w, input logic [15:0] p);
		@(posedge i_ref_clk);
		halt_req <= h;
		i_wdog_expired <= w;
		pin_cyc <= p;
		pin_go <= (p != 16'h0);
		@(posedge i_ref_clk);
		{halt_req, i_wdog_expired, pin_go} <= 3'h0;
	endtask
	////////////////
	task automatic t_por();
		wmode(PMRC_ACTIVE, CPU + 20);
		rd(STATUS_OFS, 32'hF, 32'h0, RESP_OKAY);
		rd(SYS_CTRL_TWO_OFS, 32'h4, 32'h0, RESP_OKAY);
		rd(8'h20, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'h1, RESP_SLVERR);
		chk("strobe", 1'b0, o_strobe);
		wr(SYS_CTRL_ONE_OFS, 32'h1, RESP_OKAY);
		cyc(3);
		chk("osc", 1'b1, o_osc_en & (o_mode == PMRC_ACTIVE));
		$display("power-on test done");
	endtask
	task automatic t_stby();
		i_level_busy <= 1'b1;
		drive(1'b1, 1'b0, 16'h0);
		wmode(PMRC_STANDBY, 5);
		cyc(2);
		chk("clk", 3'h3, {o_cpu_clk_en, o_osc_en, o_periph_en});
		chk("level", 1'b1, o_level_en);
		@(posedge i_ref_clk);
		i_level_busy <= 1'b0;
		cyc(3);
		chk("level", 1'b0, o_level_en);
		@(posedge i_ref_clk);
		i_irq_pending <= 1'b1;
		wmode(PMRC_ACTIVE, 5);
		@(posedge i_ref_clk);
		i_irq_pending <= 1'b0;
		$display("standby test done");
	endtask
	task automatic t_sleep();
		wr(SYS_CTRL_TWO_OFS, 32'h4, RESP_OKAY);
		wr(SYS_CTRL_ONE_OFS, 32'h1, RESP_OKAY);
		wmode(PMRC_SLEEP, 5);
		cyc(2);
		chk("sleep", 5'h1A, {o_sys_rst, o_cpu_rst, o_osc_en, o_bidir_hiz, o_input_port_en});
		drive(1'b0, 1'b0, 16'(PF / 2));
		cyc(PF);
		chk("mode", PMRC_SLEEP, o_mode);
		drive(1'b0, 1'b0, 16'(PF + 5));
		wmode(PMRC_WAKE, PF + 20);
		chk("cpu_rst", 1'b1, o_cpu_rst);
		wmode(PMRC_ACTIVE, CPU + 20);
		rd(SYS_CTRL_TWO_OFS, 32'h4, 32'h4, RESP_OKAY);
		rd(SYS_CTRL_ONE_OFS, 32'h1, 32'h0, RESP_OKAY);
		$display("sleep test done");
	endtask
	task automatic t_rst();
		drive(1'b0, 1'b1, 16'h0);
		cyc(3);
		chk("rst", 3'h7, {o_sys_rst, o_cpu_rst, o_strobe});
		wmode(PMRC_ACTIVE, CPU + 20);
		rd(SYS_CTRL_TWO_OFS, 32'h4, 32'h4, RESP_OKAY);
		wr(RST_SEL_ONE_OFS, 32'h1, RESP_OKAY);
		wr(RST_SEL_TWO_OFS, 32'hE, RESP_OKAY);
		i_input_port_pins <= 4'hF;
		cyc(DEB + 5);
		chk("mode", PMRC_ACTIVE, o_mode);
		@(posedge i_ref_clk);
		i_input_port_pins <= 4'hE;
		cyc(DEB / 2);
		chk("mode", PMRC_ACTIVE, o_mode);
		wmode(PMRC_WAKE, DEB);
		@(posedge i_ref_clk);
		i_input_port_pins <= 4'h0;
		wmode(PMRC_ACTIVE, CPU + 20);
		rd(RST_SEL_TWO_OFS, 32'hF, 32'hE, RESP_OKAY);
		wr(LVL_CTRL_OFS, 32'h1, RESP_OKAY);
		i_osc_stopped <= 1'b1;
		cyc(5);
		chk("sys_rst", 1'b0, o_sys_rst);
		wr(LVL_CTRL_OFS, 32'h0, RESP_OKAY);
		wmode(PMRC_WAKE, 5);
		@(posedge i_ref_clk);
		i_osc_stopped <= 1'b0;
		wmode(PMRC_ACTIVE, CPU + 20);
		// strobe source other than reset state: port write pulse
		wr(DISP_CTRL_OFS, 32'h1, RESP_OKAY);
		@(posedge i_ref_clk);
		i_port_write <= 1'b1;
		cyc(2);
		chk("strobe", 1'b1, o_strobe);
		@(posedge i_ref_clk);
		i_port_write <= 1'b0;
		cyc(2);
		chk("strobe", 1'b0, o_strobe);
		wr(DISP_CTRL_OFS, 32'h0, RESP_OKAY);
		$display("reset source test done");
	endtask
	////////////////
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_irq_pending, i_wdog_expired} = 7'h0;
		{i_osc_stopped, i_level_busy, i_port_write, halt_req, pin_go, i_input_port_pins} = 9'h0;
		{i_awaddr, i_araddr, i_wdata, pin_cyc} = 64'h0;
		i_wstrb = 4'hF;
		i_sys_rst = 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_sys_rst <= 1'b0;
		t_por();
		t_stby();
		t_sleep();
		t_rst();
		tally_and_finish();
	end
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		miscompares++;
		tally_and_finish();
	end
endmodule
